// ===== core/deb_if.sv
`timescale 1ns/1ps
`default_nettype none
// raw and filtered panel inputs
interface deb_if #(parameter int W = 7);
	logic [W-1:0] raw;
	logic [W-1:0] clean;
	modport filt (input raw, output clean);
	modport user (output raw, input clean);
endinterface : deb_if
`default_nettype wire

// ===== core/drive_panel_start_stop_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module drive_panel_start_stop_sequencer
	import seq_pkg::*;
#(
	parameter int unsigned SEQ_CYCLES = 32'(SEQ_CYC),
	parameter int unsigned DEB_CYCLES = 32'(DEB_CYC)
)
(
	// clock, reset, enable
	input  wire logic       CLK,
	input  wire logic       RESETN,
	input  wire logic       CE,
	// panel switches
	input  wire logic       SW_RUN,
	input  wire logic       SW_HALT,
	input  wire logic       SW_WRITE_INHIBIT,
	input  wire logic       SW_PORT_A,
	input  wire logic       SW_PORT_B,
	input  wire logic       SW_LAMP_TEST,
	input  wire logic [3:0] ADDRESS_PLUG,
	// interlocks and drive sense
	input  wire logic       DOOR_CLOSED,
	input  wire logic       PACK_PRESENT,
	input  wire logic       POWER_OK,
	input  wire logic       OTHER_SPINUP,
	input  wire logic       SPEED_OK,
	input  wire logic       SPINDLE_STOPPED,
	input  wire logic       SEQ_FAULT,
	input  wire logic       RW_SAFETY_ERR,
	// drive control unit side
	input  wire logic       CMD_STANDBY,
	input  wire logic       CMD_READ,
	input  wire logic       CMD_WRITE,
	input  wire logic       WRITING,
	input  wire logic       PORT_A_LAMP,
	input  wire logic       PORT_B_LAMP,
	output logic            PORT_A_LOCKED,
	output logic            PORT_B_LOCKED,
	output logic [3:0]      DRIVE_ADDR,
	output logic            SPINNING_UP,
	// actuators
	output logic            DOOR_LOCK,
	output logic            SPINDLE_ON,
	output logic            HEADS_LOAD,
	output logic            HEADS_RETRACT,
	output logic            BRAKE_ON,
	output logic            WRITE_EN,
	output logic            READ_EN,
	output logic            HEAD_SELECT_EN,
	// indicators
	output logic            LAMP_START,
	output logic            LAMP_READY,
	output logic            LAMP_FAULT,
	output logic            LAMP_STANDBY,
	output logic            LAMP_WRITE_INHIBIT,
	output logic            LAMP_DOOR_LOCKED,
	output logic            LAMP_PORT,
	output logic            LAMP_PORT_A,
	output logic            LAMP_PORT_B
);
	//****************************************************************
	// input filtering
	//****************************************************************
	deb_if #(.W(NUM_IN)) dbus ();
	assign dbus.raw = {SW_RUN, SW_HALT, SW_WRITE_INHIBIT, SW_PORT_A, SW_PORT_B,
		SW_LAMP_TEST, DOOR_CLOSED};

	input_debounce #(.W(NUM_IN), .DEB_MAX(DEB_CYCLES)) u_deb
	(
		.clk   (CLK),
		.rst_n (RESETN),
		.ce    (CE),
		.bus   (dbus.filt)
	);

	logic run_s, halt_s, wi_s, pa_s, pb_s, lt_s, door_s;
	assign {run_s, halt_s, wi_s, pa_s, pb_s, lt_s, door_s} = dbus.clean;

	//****************************************************************
	// sequence state
	//****************************************************************
	seq_state_e  state_reg, state_next;
	logic [31:0] tmr_reg, tmr_next;
	logic        run_d_reg, run_d_next;
	logic        pwr_go_reg, pwr_go_next;
	logic        stby_reg, stby_next;
	logic        abn_reg, abn_next;
	logic        wi_act_reg, wi_act_next;
	logic        run_press, start_ok, stop_req, tmr_done;

	assign run_press = run_s && !run_d_reg;
	assign start_ok  = door_s && PACK_PRESENT && POWER_OK && !OTHER_SPINUP && !halt_s;
	assign stop_req  = halt_s || CMD_STANDBY || !door_s;
	assign tmr_done  = (tmr_reg >= SEQ_CYCLES - 1);

	// next state of the sequencer
	always_comb
	begin
		state_next  = state_reg;
		tmr_next    = tmr_reg;
		run_d_next  = run_s;
		pwr_go_next = pwr_go_reg && tmr_reg == '0 && !run_d_reg && state_reg == ST_STOPPED
			&& !start_ok && !halt_s && !stby_reg;
		stby_next   = stby_reg;
		abn_next    = abn_reg;
		if (CMD_STANDBY)
			stby_next = 1'b1;
		unique case (state_reg)
			ST_STOPPED:
			begin
				tmr_next = '0;
				if ((run_press || pwr_go_reg) && start_ok)
				begin
					state_next = ST_SPINUP;
					stby_next  = CMD_STANDBY; // a new standby command wins
					abn_next   = 1'b0;
				end
			end
			ST_SPINUP:
			begin
				tmr_next = tmr_reg + 32'h1;
				if (stop_req)
				begin
					state_next = ST_SPINDN;
					tmr_next   = '0;
				end
				else if (SEQ_FAULT || (tmr_done && !SPEED_OK))
				begin
					state_next = ST_ABORT;
					abn_next   = 1'b1;
					tmr_next   = '0;
				end
				else if (tmr_done && SPEED_OK)
					state_next = ST_READY;
			end
			ST_READY:
			begin
				tmr_next = '0;
				if (stop_req)
					state_next = ST_SPINDN;
				else if (SEQ_FAULT)
				begin
					state_next = ST_ABORT;
					abn_next   = 1'b1;
				end
			end
			ST_SPINDN, ST_ABORT:
			begin
				if (!tmr_done)
					tmr_next = tmr_reg + 32'h1;
				if (tmr_done && SPINDLE_STOPPED)
					state_next = ST_STOPPED;
			end
			default:
				state_next = ST_STOPPED;
		endcase
	end

	// sequencer registers; power-on start request set while reset is held
	always_ff @(posedge CLK)
	begin
		if (!RESETN)
		begin
			state_reg  <= ST_STOPPED;
			tmr_reg    <= '0;
			run_d_reg  <= 1'b0;
			pwr_go_reg <= 1'b1;
			stby_reg   <= 1'b0;
			abn_reg    <= 1'b0;
		end
		else if (CE)
		begin
			state_reg  <= state_next;
			tmr_reg    <= tmr_next;
			run_d_reg  <= run_d_next;
			pwr_go_reg <= pwr_go_next;
			stby_reg   <= stby_next;
			abn_reg    <= abn_next;
		end
	end

	//****************************************************************
	// write inhibit, waits for the current write
	//****************************************************************
	always_comb
	begin
		wi_act_next = wi_act_reg;
		if (!wi_s)
			wi_act_next = 1'b0;
		else if (!WRITING)
			wi_act_next = 1'b1;
	end

	always_ff @(posedge CLK)
	begin
		if (!RESETN)
			wi_act_reg <= 1'b0;
		else if (CE)
			wi_act_reg <= wi_act_next;
	end

	//****************************************************************
	// registered outputs
	//****************************************************************
	logic        spin, ready, both_rw, rotating;
	assign ready    = (state_next == ST_READY);
	assign rotating = (state_next == ST_SPINUP) || ready;
	assign spin     = rotating && door_s;
	assign both_rw  = CMD_READ && CMD_WRITE;

	always_ff @(posedge CLK)
	begin
		if (!RESETN)
		begin
			{PORT_A_LOCKED, PORT_B_LOCKED, SPINNING_UP, DOOR_LOCK, SPINDLE_ON} <= '0;
			{HEADS_LOAD, HEADS_RETRACT, BRAKE_ON, WRITE_EN, READ_EN} <= '0;
			HEAD_SELECT_EN <= 1'b0;
			DRIVE_ADDR     <= ADDR_NONE;
			{LAMP_START, LAMP_READY, LAMP_FAULT, LAMP_STANDBY} <= '0;
			{LAMP_WRITE_INHIBIT, LAMP_DOOR_LOCKED, LAMP_PORT, LAMP_PORT_A, LAMP_PORT_B} <= '0;
		end
		else if (CE)
		begin
			PORT_A_LOCKED  <= pa_s && !pb_s;
			PORT_B_LOCKED  <= pb_s && !pa_s;
			DRIVE_ADDR     <= (ADDRESS_PLUG <= ADDR_SERVICE) ? ADDRESS_PLUG : ADDR_NONE;
			SPINNING_UP    <= (state_next == ST_SPINUP);
			DOOR_LOCK      <= (state_next != ST_STOPPED) && door_s;
			SPINDLE_ON     <= spin;
			HEADS_LOAD     <= ready && SPEED_OK;
			HEADS_RETRACT  <= !ready;
			BRAKE_ON       <= (state_next == ST_SPINDN) || (state_next == ST_ABORT);
			WRITE_EN       <= ready && CMD_WRITE && !both_rw && !wi_act_next;
			READ_EN        <= ready && CMD_READ && !both_rw;
			HEAD_SELECT_EN <= ready && !both_rw;
			LAMP_START     <= lt_s || rotating;
			LAMP_READY     <= lt_s || ready;
			LAMP_FAULT     <= lt_s || abn_next || RW_SAFETY_ERR;
			LAMP_STANDBY   <= lt_s || stby_next;
			LAMP_WRITE_INHIBIT <= lt_s || wi_s;
			LAMP_DOOR_LOCKED   <= lt_s || ((state_next != ST_STOPPED) && door_s);
			LAMP_PORT      <= lt_s || PORT_A_LAMP || PORT_B_LAMP;
			LAMP_PORT_A    <= lt_s || PORT_A_LAMP;
			LAMP_PORT_B    <= lt_s || PORT_B_LAMP;
		end
	end

	//****************************************************************
	// checks
	//****************************************************************
	sequence s_halt_seen;
		CE && state_reg == ST_READY && halt_s;
	endsequence

	property p_halt_dark;
		@(posedge CLK) disable iff (!RESETN)
		s_halt_seen |=> !LAMP_READY || lt_s;
	endproperty
	a_halt_dark: assert property (p_halt_dark) else $error("ready lamp stayed on at halt");

	property p_spin_door;
		@(posedge CLK) disable iff (!RESETN)
		SPINDLE_ON |-> DOOR_LOCK;
	endproperty
	a_spin_door: assert property (p_spin_door) else $error("spindle on with door unlocked");

	property p_heads_speed;
		@(posedge CLK) disable iff (!RESETN)
		HEADS_LOAD |-> $past(SPEED_OK) && SPINDLE_ON;
	endproperty
	a_heads_speed: assert property (p_heads_speed) else $error("heads loaded below speed");

	property p_rw_both;
		@(posedge CLK) disable iff (!RESETN)
		CE && CMD_READ && CMD_WRITE |=> !READ_EN && !WRITE_EN && !HEAD_SELECT_EN;
	endproperty
	a_rw_both: assert property (p_rw_both) else $error("read and write both enabled");

	property p_ports;
		@(posedge CLK) disable iff (!RESETN)
		!(PORT_A_LOCKED && PORT_B_LOCKED);
	endproperty
	a_ports: assert property (p_ports) else $error("both port lines true");

	property p_lamp_test;
		@(posedge CLK) disable iff (!RESETN)
		CE && lt_s |=> LAMP_START && LAMP_READY && LAMP_FAULT && LAMP_STANDBY
			&& LAMP_DOOR_LOCKED && LAMP_PORT_A && LAMP_PORT_B;
	endproperty
	a_lamp_test: assert property (p_lamp_test) else $error("lamp test missed a lamp");

	property p_write_hold;
		@(posedge CLK) disable iff (!RESETN)
		CE && wi_act_reg && wi_s |=> !WRITE_EN;
	endproperty
	a_write_hold: assert property (p_write_hold) else $error("write passed while inhibited");

	property p_unlock;
		@(posedge CLK) disable iff (!RESETN)
		$fell(DOOR_LOCK) && door_s |-> $past(SPINDLE_STOPPED);
	endproperty
	a_unlock: assert property (p_unlock) else $error("door unlocked while rotating");
endmodule : drive_panel_start_stop_sequencer
`default_nettype wire

// ===== core/input_debounce.sv
`timescale 1ns/1ps
`default_nettype none
module input_debounce
	import seq_pkg::*;
#(
	parameter int          W       = NUM_IN,
	parameter int unsigned DEB_MAX = 32'(DEB_CYC)
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	deb_if.filt      bus
);
	logic [W-1:0] s1_reg, s2_reg, s1_next, s2_next;

	//************************************************************
	// two-stage synchroniser
	//************************************************************
	always_comb
	begin
		s1_next = bus.raw;
		s2_next = s1_reg;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s1_reg <= '0;
			s2_reg <= '0;
		end
		else if (ce)
		begin
			s1_reg <= s1_next;
			s2_reg <= s2_next;
		end
	end

	// per-bit stable-time filter
	genvar g;
	generate
		for (g = 0; g < W; g++)
		begin : g_bit
			logic [31:0] cnt_reg, cnt_next;
			logic        out_reg, out_next;
			always_comb
			begin
				cnt_next = '0;
				out_next = out_reg;
				if (s2_reg[g] != out_reg)
				begin
					cnt_next = cnt_reg + 32'h1;
					if (cnt_reg >= DEB_MAX - 1)
					begin
						out_next = s2_reg[g];
						cnt_next = '0;
					end
				end
			end
			always_ff @(posedge clk)
			begin
				if (!rst_n)
				begin
					cnt_reg <= '0;
					out_reg <= 1'b0;
				end
				else if (ce)
				begin
					cnt_reg <= cnt_next;
					out_reg <= out_next;
				end
			end
			assign bus.clean[g] = out_reg;
		end
	endgenerate
endmodule : input_debounce
`default_nettype wire

// ===== core/seq_pkg.sv
//********************************************************************
// operation constants
//********************************************************************
// Operation
// - run press with door closed locks door, starts
// - heads load only after spindle at speed
// - halt retracts heads, brakes, unlocks when stopped
// - start and stop sequences last about 20 s
// - run press clears standby if set
// - centre switch starts drive at power-up
// - write inhibit blocks writes after current write
// - read plus write together deselects heads
// - port switch drives port reservation lines
// - address plug gives nine drive designations
// - lamp test forces every indicator on
// - start lamp lit from start until stop begins
// - port lamps follow control unit lamp lines
// - ready lamp lit exactly while on line
// - fault lamp on abnormal stop or safety error
// - standby start needs conditions, pack, door, slot
// - write inhibit lamp follows switch
// - rotation only while door locked
// - door forced open triggers normal stop
// - run press: start, rotate, lock; ready later
// - halt darkens ready, start; unlock after stop
// - control unit standby acts as stop, lights standby
package seq_pkg;
	localparam int unsigned CLK_HZ       = 125_000_000;
	localparam int unsigned SEQ_TIME_S   = 20;
	localparam longint unsigned SEQ_CYC  = longint'(SEQ_TIME_S) * CLK_HZ;
	localparam int unsigned DEB_TIME_US  = 10_000;
	localparam longint unsigned DEB_CYC  = longint'(DEB_TIME_US) * (CLK_HZ / 1_000_000);
	localparam int unsigned NUM_IN       = 7;
	localparam logic [3:0]  ADDR_SERVICE = 4'h8;
	localparam logic [3:0]  ADDR_NONE    = 4'hF;

	typedef enum logic [2:0]
	{
		ST_STOPPED = 3'b000,
		ST_SPINUP  = 3'b001,
		ST_READY   = 3'b011,
		ST_SPINDN  = 3'b010,
		ST_ABORT   = 3'b110
	} seq_state_e;
endpackage : seq_pkg

// ===== dv/drive_panel_start_stop_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
module drive_panel_start_stop_sequencer_test;
	import seq_pkg::*;
	typedef struct packed {
		logic [3:0] sw;
		logic       wi;
		logic [3:0] addr;
		logic [1:0] lock;
		logic [2:0] plamp;
		logic [3:0] eaddr;
	} row_s;
	logic CLK, RESETN, CE, SW_RUN, SW_HALT, SW_WRITE_INHIBIT, SW_PORT_A, SW_PORT_B, SW_LAMP_TEST;
	logic DOOR_CLOSED, PACK_PRESENT, POWER_OK, OTHER_SPINUP, SPEED_OK, SPINDLE_STOPPED;
	logic SEQ_FAULT, RW_SAFETY_ERR, CMD_STANDBY, CMD_READ, CMD_WRITE, WRITING, STUCK;
	logic PORT_A_LAMP, PORT_B_LAMP, PORT_A_LOCKED, PORT_B_LOCKED, SPINNING_UP, DOOR_LOCK;
	logic SPINDLE_ON, HEADS_LOAD, HEADS_RETRACT, BRAKE_ON, WRITE_EN, READ_EN, HEAD_SELECT_EN;
	logic LAMP_START, LAMP_READY, LAMP_FAULT, LAMP_STANDBY, LAMP_WRITE_INHIBIT;
	logic LAMP_DOOR_LOCKED, LAMP_PORT, LAMP_PORT_A, LAMP_PORT_B;
	logic [3:0] ADDRESS_PLUG, DRIVE_ADDR;
	int n_errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	int n;
	row_s rows[6] = '{
		'{4'h8, 1'h0, 4'h0, 2'h2, 3'h0, 4'h0},
		'{4'h6, 1'h1, 4'h7, 2'h1, 3'h6, 4'h7},
		'{4'h1, 1'h0, 4'h8, 2'h0, 3'h5, 4'h8},
		'{4'hF, 1'h1, 4'h3, 2'h0, 3'h7, 4'h3},
		'{4'h0, 1'h0, 4'h9, 2'h0, 3'h0, 4'hF},
		'{4'h0, 1'h0, 4'hF, 2'h0, 3'h0, 4'hF}
	};

	drive_panel_start_stop_sequencer #(.SEQ_CYCLES(50), .DEB_CYCLES(4))
		drive_panel_start_stop_sequencer_i (.CLK(CLK), .RESETN(RESETN), .CE(CE),
		.SW_RUN(SW_RUN), .SW_HALT(SW_HALT), .SW_WRITE_INHIBIT(SW_WRITE_INHIBIT),
		.SW_PORT_A(SW_PORT_A), .SW_PORT_B(SW_PORT_B), .SW_LAMP_TEST(SW_LAMP_TEST),
		.ADDRESS_PLUG(ADDRESS_PLUG), .DOOR_CLOSED(DOOR_CLOSED), .PACK_PRESENT(PACK_PRESENT),
		.POWER_OK(POWER_OK), .OTHER_SPINUP(OTHER_SPINUP), .SPEED_OK(SPEED_OK),
		.SPINDLE_STOPPED(SPINDLE_STOPPED), .SEQ_FAULT(SEQ_FAULT), .RW_SAFETY_ERR(RW_SAFETY_ERR),
		.CMD_STANDBY(CMD_STANDBY), .CMD_READ(CMD_READ), .CMD_WRITE(CMD_WRITE), .WRITING(WRITING),
		.PORT_A_LAMP(PORT_A_LAMP), .PORT_B_LAMP(PORT_B_LAMP), .PORT_A_LOCKED(PORT_A_LOCKED),
		.PORT_B_LOCKED(PORT_B_LOCKED), .DRIVE_ADDR(DRIVE_ADDR), .SPINNING_UP(SPINNING_UP),
		.DOOR_LOCK(DOOR_LOCK), .SPINDLE_ON(SPINDLE_ON), .HEADS_LOAD(HEADS_LOAD),
		.HEADS_RETRACT(HEADS_RETRACT), .BRAKE_ON(BRAKE_ON), .WRITE_EN(WRITE_EN),
		.READ_EN(READ_EN), .HEAD_SELECT_EN(HEAD_SELECT_EN), .LAMP_START(LAMP_START),
		.LAMP_READY(LAMP_READY), .LAMP_FAULT(LAMP_FAULT), .LAMP_STANDBY(LAMP_STANDBY),
		.LAMP_WRITE_INHIBIT(LAMP_WRITE_INHIBIT), .LAMP_DOOR_LOCKED(LAMP_DOOR_LOCKED),
		.LAMP_PORT(LAMP_PORT), .LAMP_PORT_A(LAMP_PORT_A), .LAMP_PORT_B(LAMP_PORT_B));

	spindle_model #(.RAMP(30)) spindle_model_i (.CLK(CLK), .SPINDLE_ON(SPINDLE_ON),
		.BRAKE_ON(BRAKE_ON), .STUCK(STUCK), .SPEED_OK(SPEED_OK),
		.SPINDLE_STOPPED(SPINDLE_STOPPED));

	// clock, 8 ns period
	initial
	begin
		CLK = 1'h0;
		forever #4 CLK = ~CLK;
	end

	// hang guard
	always @(posedge CLK)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			n_errors++;
			stop_test();
		end
	end

	task automatic stop_test();
		if (n_errors == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : stop_test

	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic cyc(input int k);
		repeat (k) @(posedge CLK);
		#1;
	endtask : cyc

	function automatic logic sig(input int sel);
		case (sel)
			0: return LAMP_START;
			1: return LAMP_READY;
			2: return LAMP_DOOR_LOCKED;
			3: return LAMP_FAULT;
			default: return BRAKE_ON;
		endcase
	endfunction : sig

	// bounded wait for a lamp or the brake to reach a level, k returns the cycles taken
	task automatic wait_on(input int sel, input logic lvl, input int lim, output int k);
		k = 0;
		while (sig(sel) !== lvl && k < lim)
		begin
			cyc(1);
			k++;
		end
	endtask : wait_on

	// momentary run press, held past the filter
	task automatic press_run();
		SW_RUN = 1'h1;
		cyc(10);
		SW_RUN = 1'h0;
		cyc(10);
	endtask : press_run

	// main sequence
	initial
	begin
		{RESETN, SW_RUN, SW_HALT, SW_WRITE_INHIBIT, SW_PORT_A, SW_PORT_B, SW_LAMP_TEST} = 7'h00;
		{OTHER_SPINUP, SEQ_FAULT, RW_SAFETY_ERR, CMD_STANDBY, CMD_READ, CMD_WRITE} = 6'h00;
		{WRITING, PORT_A_LAMP, PORT_B_LAMP, STUCK} = 4'h0;
		{CE, DOOR_CLOSED, PACK_PRESENT, POWER_OK} = 4'hF;
		ADDRESS_PLUG = 4'h2;
		cyc(5);
		chk("reset addr", DRIVE_ADDR, 16'h000F);
		chk("reset lock", {DOOR_LOCK, LAMP_START, LAMP_READY}, 16'h0000);
		RESETN = 1'h1;
		wait_on(0, 1'h1, 40, n);
		chk("auto start", LAMP_START, 16'h0001);
		chk("rotate locked", {LAMP_DOOR_LOCKED, DOOR_LOCK, SPINDLE_ON, SPINNING_UP}, 16'h000F);
		chk("heads early", HEADS_LOAD, 16'h0000);
		wait_on(1, 1'h1, 120, n);
		chk("ready", LAMP_READY, 16'h0001);
		chk("spinup long", 16'(n >= 48), 16'h0001);
		chk("heads loaded", {HEADS_LOAD, HEADS_RETRACT, SPINNING_UP}, 16'h0004);
		{CMD_WRITE, WRITING} = 2'h3;
		cyc(3);
		SW_WRITE_INHIBIT = 1'h1;
		cyc(12);
		chk("write held", WRITE_EN, 16'h0001);
		chk("wi lamp", LAMP_WRITE_INHIBIT, 16'h0001);
		WRITING = 1'h0;
		cyc(3);
		chk("write blocked", WRITE_EN, 16'h0000);
		{SW_WRITE_INHIBIT, CMD_READ} = 2'h1;
		cyc(12);
		chk("rw clash", {READ_EN, WRITE_EN, HEAD_SELECT_EN}, 16'h0000);
		CMD_WRITE = 1'h0;
		cyc(3);
		chk("read only", {READ_EN, HEAD_SELECT_EN}, 16'h0003);
		{CMD_READ, SW_LAMP_TEST} = 2'h1;
		cyc(12);
		chk("lamp test", {LAMP_START, LAMP_READY, LAMP_FAULT, LAMP_STANDBY, LAMP_WRITE_INHIBIT,
			LAMP_DOOR_LOCKED, LAMP_PORT, LAMP_PORT_A, LAMP_PORT_B}, 16'h01FF);
		SW_LAMP_TEST = 1'h0;
		cyc(12);
		chk("fault dark", LAMP_FAULT, 16'h0000);
		RW_SAFETY_ERR = 1'h1;
		cyc(3);
		chk("safety fault", LAMP_FAULT, 16'h0001);
		{RW_SAFETY_ERR, DOOR_CLOSED} = 2'h0;
		wait_on(1, 1'h0, 20, n);
		chk("door stop", {LAMP_START, BRAKE_ON, HEADS_RETRACT}, 16'h0003);
		chk("door lamp", {LAMP_DOOR_LOCKED, SPINDLE_ON}, 16'h0000);
		wait_on(4, 1'h0, 150, n);
		chk("spindown long", 16'(n >= 45), 16'h0001);
		chk("unlocked", DOOR_LOCK, 16'h0000);
		DOOR_CLOSED = 1'h1;
		cyc(12);
		press_run();
		chk("run press", {LAMP_START, DOOR_LOCK}, 16'h0003);
		wait_on(1, 1'h1, 120, n);
		CMD_STANDBY = 1'h1;
		cyc(1);
		CMD_STANDBY = 1'h0;
		cyc(2);
		chk("standby stop", {LAMP_STANDBY, LAMP_READY, LAMP_START}, 16'h0004);
		wait_on(2, 1'h0, 150, n);
		OTHER_SPINUP = 1'h1;
		press_run();
		chk("refused", {LAMP_START, LAMP_STANDBY}, 16'h0001);
		OTHER_SPINUP = 1'h0;
		press_run();
		chk("standby clear", {LAMP_START, LAMP_STANDBY}, 16'h0002);
		wait_on(1, 1'h1, 120, n);
		SW_HALT = 1'h1;
		wait_on(1, 1'h0, 20, n);
		chk("halt dark", LAMP_START, 16'h0000);
		wait_on(2, 1'h0, 150, n);
		// table of panel mappings while halted
		foreach (rows[i])
		begin
			{SW_PORT_A, SW_PORT_B, PORT_A_LAMP, PORT_B_LAMP} = rows[i].sw;
			SW_WRITE_INHIBIT = rows[i].wi;
			ADDRESS_PLUG = rows[i].addr;
			cyc(12);
			chk("port lines", {PORT_A_LOCKED, PORT_B_LOCKED}, 16'(rows[i].lock));
			chk("port lamps", {LAMP_PORT, LAMP_PORT_A, LAMP_PORT_B}, 16'(rows[i].plamp));
			chk("address", DRIVE_ADDR, 16'(rows[i].eaddr));
			chk("wi lamp row", LAMP_WRITE_INHIBIT, 16'(rows[i].wi));
		end
		{SW_HALT, STUCK} = 2'h1;
		cyc(12);
		press_run();
		wait_on(3, 1'h1, 120, n);
		chk("abort fault", {LAMP_FAULT, LAMP_READY, HEADS_LOAD}, 16'h0004);
		// mid-run reset during the abort, then the power-on start again
		RESETN = 1'h0;
		STUCK = 1'h0;
		cyc(2);
		chk("reset mid", {DOOR_LOCK, BRAKE_ON, LAMP_FAULT, LAMP_READY}, 16'h0000);
		RESETN = 1'h1;
		wait_on(0, 1'h1, 40, n);
		chk("restart", {LAMP_START, HEADS_LOAD}, 16'h0002);
		// enable low freezes the sequence timer
		CE = 1'h0;
		cyc(60);
		chk("ce freeze", {LAMP_START, LAMP_READY}, 16'h0002);
		CE = 1'h1;
		wait_on(1, 1'h1, 120, n);
		chk("ready after freeze", LAMP_READY, 16'h0001);
		// sequence fault while ready gives an abnormal stop
		SEQ_FAULT = 1'h1;
		cyc(1);
		SEQ_FAULT = 1'h0;
		cyc(2);
		chk("seq fault", {LAMP_FAULT, LAMP_READY, BRAKE_ON}, 16'h0005);
		stop_test();
	end
endmodule : drive_panel_start_stop_sequencer_test
`default_nettype wire

// ===== dv/spindle_model.sv
`timescale 1ns/1ps
`default_nettype none
module spindle_model
#(
	parameter int RAMP = 30
)
(
	// clock
	input  wire logic CLK,
	// drive commands
	input  wire logic SPINDLE_ON,
	input  wire logic BRAKE_ON,
	input  wire logic STUCK,
	// sense lines
	output logic      SPEED_OK,
	output logic      SPINDLE_STOPPED
);
	int spd = 0;

	// speed rises while powered, falls under braking; stuck stalls short of speed
	always_ff @(posedge CLK)
	begin
		if (SPINDLE_ON && !BRAKE_ON && spd < RAMP - (STUCK ? 2 : 0))
			spd <= spd + 1;
		else if ((!SPINDLE_ON || BRAKE_ON) && spd > 0)
			spd <= spd - 1;
	end

	// sense lines report the two thresholds
	assign SPEED_OK        = (spd == RAMP);
	assign SPINDLE_STOPPED = (spd == 0);
endmodule : spindle_model
`default_nettype wire
